// ==== tb/chmon_properties.sv ====
// concurrent checks on the channel monitor ports
`timescale 1ns/1ps
module chmon_properties
  import chmon_pkg::*;
#(
  parameter int unsigned NCH = 40
) (
  // clock, reset and inputs
  input wire logic                       clk_i,
  input wire logic                       resetn_i,
  input wire logic [NCH-1:0]             cmd_on_i,
  input wire logic [NCH/GRP_SIZE-1:0]    sup_ok_i,
  input wire logic [NCH-1:0]             overcur_i,
  input wire logic                       fault_reset_i,
  input wire logic                       fsup_mon_en_i,
  input wire logic [NUM_FSUP-1:0]        fsup_ok_i,
  input wire logic                       evt_ack_i,
  // outputs
  input wire logic [NCH-1:0][CODE_W-1:0] state_code_o,
  input wire logic [NCH-1:0]             line_fault_o,
  input wire logic [NUM_FSUP-1:0]        fsup_alarm_o,
  input wire logic                       evt_valid_o,
  input wire logic [TS_W-1:0]            evt_time_o,
  input wire logic                       link_dat_o,
  input wire logic                       link_sync_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // alarm expected from one cycle earlier
  wire logic [NUM_FSUP-1:0] fsup_exp = {NUM_FSUP{fsup_mon_en_i}} & ~fsup_ok_i;
  // frame marker covers one whole bit slot; no bit is shorter
  sequence sync_span;
    link_sync_o[*8] ##1 !link_sync_o;
  endsequence
  sequence bit_hold;
    $stable(link_dat_o)[*7];
  endsequence
  no_supply_a: assert property (!sup_ok_i[0] |=> state_code_o[0] == ST_NOSUP)
    else $error("no supply code missing");
  short_set_a: assert property (sup_ok_i[0] && cmd_on_i[0] && overcur_i[0]
    |=> state_code_o[0] == ST_SHORT) else $error("short not latched");
  short_hold_a: assert property (state_code_o[0] == ST_SHORT && sup_ok_i[0]
    && !fault_reset_i && $stable(cmd_on_i[0]) |=> state_code_o[0] == ST_SHORT)
    else $error("short latch lost");
  fault_map_a: assert property (line_fault_o[0] == state_code_o[0][0]
    && line_fault_o[NCH-1] == state_code_o[NCH-1][0]) else $error("fault flag wrong");
  fsup_alarm_a: assert property (1'b1 |=> fsup_alarm_o == $past(fsup_exp))
    else $error("supply alarm wrong");
  event_hold_a: assert property (evt_valid_o && !evt_ack_i
    |=> evt_valid_o && $stable(evt_time_o)) else $error("event not held");
  sync_span_a: assert property ($rose(link_sync_o) |-> sync_span)
    else $error("sync width wrong");
  bit_hold_a: assert property ($changed(link_dat_o) |=> bit_hold)
    else $error("link bit too short");
endmodule

// ==== tb/host_model.sv ====
// host slice model: reads each held event after 0 to 3 idle cycles
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clk_i,
  // event read port
  input  wire logic       evt_valid_i,
  input  wire logic [1:0] dly_i,
  output logic            evt_ack_o = 1'b0
);
  logic [1:0] wait_r = 2'b00;
  // strobe moves on the falling edge so it is steady when sampled
  always @(negedge clk_i) begin
    if (evt_ack_o) begin
      evt_ack_o <= 1'b0;
    end else if (evt_valid_i && wait_r == dly_i) begin
      evt_ack_o <= 1'b1;
      wait_r    <= 2'b00;
    end else if (evt_valid_i) begin
      wait_r <= wait_r + 2'd1;
    end
  end
endmodule

// ==== tb/tb_output_channel_state_monitor.sv ====
// self-checking bench for the output channel state monitor
`timescale 1ns/1ps
module tb_output_channel_state_monitor;
  import chmon_pkg::*;
  localparam int unsigned N = 40;
  typedef struct packed {logic [5:0] ch; logic [2:0] st; logic [31:0] dt;} note_t;
  logic              clk_i = 1'b0, resetn_i = 1'b0, fault_reset_i = 1'b1, fsup_mon_en_i = 1'b0;
  logic              evt_ack_i, evt_valid_o, evt_fault_o, link_dat_o, link_sync_o;
  logic [4:0]        sup_ok_i = '1;
  logic [1:0]        fsup_ok_i = '1, dly = '0, fsup_alarm_o;
  logic [N-1:0]      cmd_on_i = '0, overcur_i = '0, volt_on_i = '0, load_cur_i = '0;
  logic [N-1:0]      low_res_i = '0, off_short_en_i = '0, log_en_i = '0, line_fault_o;
  logic [N-1:0]      stuck_on_o, stuck_off_o;
  logic [N-1:0][2:0] state_code_o;
  logic [5:0]        evt_ch_o;
  logic [2:0]        evt_state_o;
  logic [31:0]       evt_time_o, last_t = '0, cycles = '0, seed = 32'h0000_fcc3;
  note_t             notes[$];
  int                miscompares = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  output_channel_state_monitor #(.NCH(N), .MS_CYC(10)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_on_i(cmd_on_i), .sup_ok_i(sup_ok_i),
    .overcur_i(overcur_i), .volt_on_i(volt_on_i), .load_cur_i(load_cur_i),
    .low_res_i(low_res_i), .off_short_en_i(off_short_en_i), .log_en_i(log_en_i),
    .fault_reset_i(fault_reset_i), .fsup_mon_en_i(fsup_mon_en_i), .fsup_ok_i(fsup_ok_i),
    .state_code_o(state_code_o), .line_fault_o(line_fault_o), .stuck_on_o(stuck_on_o),
    .stuck_off_o(stuck_off_o), .fsup_alarm_o(fsup_alarm_o), .evt_ack_i(evt_ack_i),
    .evt_valid_o(evt_valid_o), .evt_ch_o(evt_ch_o), .evt_state_o(evt_state_o),
    .evt_fault_o(evt_fault_o), .evt_time_o(evt_time_o), .link_dat_o(link_dat_o),
    .link_sync_o(link_sync_o));
  host_model u_host (.clk_i(clk_i), .evt_valid_i(evt_valid_o), .dly_i(dly),
    .evt_ack_o(evt_ack_i));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // supply first, then short, open, plain on or off
  function automatic logic [2:0] exp_code(input int i);
    if (!sup_ok_i[i/GRP_SIZE]) return 3'h1;
    if (cmd_on_i[i] ? overcur_i[i] : off_short_en_i[i] & low_res_i[i]) return 3'h5;
    if (cmd_on_i[i]) return load_cur_i[i] ? 3'h4 : 3'h3;
    return 3'h2;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compares each read event with the oldest note
  always @(posedge clk_i) begin
    if (evt_valid_o && evt_ack_i) begin
      if (notes.size() == 0) begin
        check(evt_ch_o, 32'hffff_ffff);
      end else begin
        check(evt_ch_o, notes[0].ch);
        check(evt_state_o, notes[0].st);
        check(evt_fault_o, notes[0].st[0]);
        if (notes[0].dt != 32'hffff_ffff) begin
          check(evt_time_o - last_t, notes[0].dt);
        end
        void'(notes.pop_front());
      end
      last_t = evt_time_o;
    end
  end
  // hang guard well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 32'd1;
    if (cycles == 32'd10000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    logic [2:0] c;
    step(8);
    resetn_i = 1'b1;
    // random rounds; fault reset held so codes follow the inputs
    for (int r = 0; r < 16; r++) begin
      {cmd_on_i, overcur_i} = 80'({rnd(), rnd(), rnd()});
      {load_cur_i, volt_on_i} = 80'({rnd(), rnd(), rnd()});
      {low_res_i, off_short_en_i} = 80'({rnd(), rnd(), rnd()});
      {sup_ok_i, fsup_ok_i, fsup_mon_en_i} = 8'(rnd());
      step(2);
      for (int i = 0; i < N; i++) begin
        c = exp_code(i);
        check(state_code_o[i], c);
        check(line_fault_o[i], c[0]);
      end
      check(fsup_alarm_o, {2{fsup_mon_en_i}} & ~fsup_ok_i);
    end
    $display("classification test done");
    // serial frame: channel 0 first, fault bit then code msb first
    repeat (2) @(posedge link_sync_o);
    step(4);
    for (int i = 0; i < N; i++) begin
      c = exp_code(i);
      for (int b = 3; b >= 0; b--) begin
        check(link_dat_o, {c[0], c} >> b & 4'h1);
        step(8);
      end
    end
    $display("link test done");
    fault_reset_i = 1'b0;
    sup_ok_i = '1;
    off_short_en_i = '0;
    cmd_on_i = '0;
    overcur_i = '0;
    load_cur_i = '1;
    cmd_on_i[0] = 1'b1;
    overcur_i[0] = 1'b1;
    step(2);
    overcur_i[0] = 1'b0;
    step(3);
    check(state_code_o[0], ST_SHORT);
    cmd_on_i[0] = 1'b0;
    step(2);
    check(state_code_o[0], ST_OFF);
    // fault reset high: a new hit wins, old sticky flags go
    fault_reset_i = 1'b1;
    cmd_on_i[0] = 1'b1;
    overcur_i[0] = 1'b1;
    cmd_on_i[2] = 1'b1;
    volt_on_i = 40'h00_0000_0003;
    step(2);
    // fault reset low: short latch and stuck flags must hold on their own
    fault_reset_i = 1'b0;
    overcur_i[0] = 1'b0;
    cmd_on_i[2] = 1'b0;
    volt_on_i = 40'h00_0000_0001;
    step(2);
    check(state_code_o[0], ST_SHORT);
    check(stuck_on_o[31:0], 32'h0000_0002);
    check(stuck_off_o[31:0], 32'h0000_0004);
    check({stuck_on_o[N-1:32], stuck_off_o[N-1:32]}, 32'h0000_0000);
    // a second fault reset clears the latch and both flag sets
    fault_reset_i = 1'b1;
    step(2);
    check(state_code_o[0], ST_ON);
    check(stuck_on_o[31:0], 32'h0000_0000);
    check(stuck_off_o[31:0], 32'h0000_0000);
    check({stuck_on_o[N-1:32], stuck_off_o[N-1:32]}, 32'h0000_0000);
    fault_reset_i = 1'b0;
    $display("latch test done");
    log_en_i = 40'h00_0000_0228;
    // channel 6 is not logged and must add nothing
    for (int k = 0; k < 6; k++) begin
      cmd_on_i[5] = ~cmd_on_i[5];
      cmd_on_i[6] = ~cmd_on_i[6];
      load_cur_i[5] = k[1];
      dly <= 2'(rnd());
      notes.push_back({6'd5, exp_code(5), (k == 0) ? 32'hffff_ffff : 32'd3});
      step(30);
    end
    cmd_on_i[3] = 1'b1;
    cmd_on_i[9] = 1'b1;
    notes.push_back({6'd3, exp_code(3), 32'd3});
    notes.push_back({6'd9, exp_code(9), 32'd0});
    step(30);
    check(notes.size(), 32'd0);
    $display("event test done");
    stop_test();
  end
endmodule
bind output_channel_state_monitor chmon_properties #(.NCH(NCH)) u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .cmd_on_i(cmd_on_i), .sup_ok_i(sup_ok_i),
  .overcur_i(overcur_i), .fault_reset_i(fault_reset_i), .fsup_mon_en_i(fsup_mon_en_i),
  .fsup_ok_i(fsup_ok_i), .evt_ack_i(evt_ack_i), .state_code_o(state_code_o),
  .line_fault_o(line_fault_o), .fsup_alarm_o(fsup_alarm_o), .evt_valid_o(evt_valid_o),
  .evt_time_o(evt_time_o), .link_dat_o(link_dat_o), .link_sync_o(link_sync_o));

// ==== verilog/chmon_pkg.sv ====
// shared constants for the output channel state monitor
package chmon_pkg;

  // ----------------------------------------------------------------
  // channel organisation
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH     = 40;
  localparam int unsigned GRP_SIZE   = 8;
  localparam int unsigned NUM_FSUP   = 2;
  localparam int unsigned CODE_W     = 3;
  localparam int unsigned TS_W       = 32;
  localparam int unsigned LINK_WORD_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TS_RES_MS   = 1;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned LINK_BPS    = 6_250_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S * TS_RES_MS;
  localparam int unsigned CYC_PER_BIT = CLK_HZ / LINK_BPS;

  // ----------------------------------------------------------------
  // numerical output state codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ST_NONE  = 3'h0;
  localparam logic [CODE_W-1:0] ST_NOSUP = 3'h1;
  localparam logic [CODE_W-1:0] ST_OFF   = 3'h2;
  localparam logic [CODE_W-1:0] ST_OPEN  = 3'h3;
  localparam logic [CODE_W-1:0] ST_ON    = 3'h4;
  localparam logic [CODE_W-1:0] ST_SHORT = 3'h5;

  // priority: missing supply, short, open, then plain on or off
  function automatic logic [CODE_W-1:0] classify(input logic sup_ok, input logic shorted,
                                                 input logic cmd_on, input logic load_cur);
    logic [CODE_W-1:0] c;
    if (!sup_ok) begin
      c = ST_NOSUP;
    end else if (shorted) begin
      c = ST_SHORT;
    end else if (cmd_on && !load_cur) begin
      c = ST_OPEN;
    end else if (cmd_on) begin
      c = ST_ON;
    end else begin
      c = ST_OFF;
    end
    return c;
  endfunction

  // line fault is set for every code except the two healthy ones and ST_NONE
  function automatic logic is_fault(input logic [CODE_W-1:0] c);
    return (c != ST_ON) && (c != ST_OFF) && (c != ST_NONE);
  endfunction

endpackage

// ==== verilog/output_channel_state_monitor.sv ====
// field-side slice: per-channel state classification, event capture and serial report
`timescale 1ns/1ps
// Notes on behaviour
// RL1: forty channels, each with its own independent monitoring and reporting logic.
// RL2: state follows measured current and voltage continuously, no host action needed.
// RL3: codes 5 short, 4 on, 3 open, 2 off, 1 no supply.
// RL4: line fault flag is 1 for short, open, no supply; else 0.
// RL5: open and short circuits in wiring and load detected automatically.
// RL6: diagnostics flag a switching stage stuck on or stuck off.
// RL7: each change of a channel's state makes an event entry; here a second change before hand-out overwrites the pending entry.
// RL8: event timestamps count in steps of 1 ms.
// RL9: channels form isolated supply groups of eight consecutive channels.
// RL10: slice talks to one host slice over a 6.25 Mbit/s serial link.
// RL11: two extra measurement channels watch the external field supply voltage.
// RL12: three independent host slices; a fault in one spares the others.
// RL13: on change the timer is captured; host read returns state plus timestamp.
// RL14: event logging is enabled per channel; disabled channels make no entries.
// RL15: latched short holds until fault reset or commanded state transition.
// RL16: report order: missing supply, short, open, then on or off.
module output_channel_state_monitor
  import chmon_pkg::*;
#(
  parameter int unsigned NCH    = NUM_CH,
  parameter int unsigned MS_CYC = CYC_PER_MS
) (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               resetn_i,
  // channel command and measurements
  input  wire logic [NCH-1:0]                     cmd_on_i,
  input  wire logic [NCH/GRP_SIZE-1:0]            sup_ok_i,
  input  wire logic [NCH-1:0]                     overcur_i,
  input  wire logic [NCH-1:0]                     volt_on_i,
  input  wire logic [NCH-1:0]                     load_cur_i,
  input  wire logic [NCH-1:0]                     low_res_i,
  // configuration and control
  input  wire logic [NCH-1:0]                     off_short_en_i,
  input  wire logic [NCH-1:0]                     log_en_i,
  input  wire logic                               fault_reset_i,
  input  wire logic                               fsup_mon_en_i,
  input  wire logic [NUM_FSUP-1:0]                fsup_ok_i,
  // channel status
  output logic [NCH-1:0][CODE_W-1:0]              state_code_o,
  output logic [NCH-1:0]                          line_fault_o,
  output logic [NCH-1:0]                          stuck_on_o,
  output logic [NCH-1:0]                          stuck_off_o,
  output logic [NUM_FSUP-1:0]                     fsup_alarm_o,
  // event read port
  input  wire logic                               evt_ack_i,
  output logic                                    evt_valid_o,
  output logic [$clog2(NCH)-1:0]                  evt_ch_o,
  output logic [CODE_W-1:0]                       evt_state_o,
  output logic                                    evt_fault_o,
  output logic [TS_W-1:0]                         evt_time_o,
  // serial link to host slice
  output logic                                    link_dat_o,
  output logic                                    link_sync_o
);
  localparam int unsigned CH_W = $clog2(NCH);
  localparam logic [CH_W-1:0] LAST_CH = CH_W'(NCH - 1);
  localparam logic [1:0] LAST_BIT = 2'(LINK_WORD_W - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0][CODE_W-1:0] code;
    logic [NCH-1:0]             fault;
    logic [NCH-1:0]             short_lat;
    logic [NCH-1:0]             cmd_prev;
    logic [NCH-1:0]             stuck_on;
    logic [NCH-1:0]             stuck_off;
    logic [NCH-1:0]             pend;
    logic [NCH-1:0][CODE_W-1:0] ev_code;
    logic [NCH-1:0][TS_W-1:0]   ev_ts;
    logic [TS_W-1:0]            ms;
    logic                       evt_valid;
    logic [CH_W-1:0]            evt_ch;
    logic [CODE_W-1:0]          evt_state;
    logic                       evt_fault;
    logic [TS_W-1:0]            evt_time;
    logic [CH_W-1:0]            lk_ch;
    logic [1:0]                 lk_bit;
    logic                       lk_dat;
    logic                       lk_sync;
    logic [NUM_FSUP-1:0]        fsup_alarm;
  } mon_state_t;

  mon_state_t r;
  mon_state_t n;

  // lowest pending channel, msb is the found flag
  function automatic logic [CH_W:0] first_pend(input logic [NCH-1:0] p);
    logic [CH_W:0] s;
    s = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (p[k]) begin
        s = {1'b1, CH_W'(k)};
      end
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // rate enables: timestamp tick and link bit tick
  // ----------------------------------------------------------------
  tick_if ms_t ();
  tick_if bit_t ();

  rate_div #(.DIV(MS_CYC)) u_ms_div (   // see RL8
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (ms_t)
  );

  rate_div #(.DIV(CYC_PER_BIT)) u_bit_div (   // see RL10
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (bit_t)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    int unsigned       g;
    logic              clr;
    logic              sset;
    logic [CODE_W-1:0] c;
    logic [CH_W:0]     sel;
    logic [LINK_WORD_W-1:0] word;
    g    = 0;
    clr  = 1'b0;
    sset = 1'b0;
    c    = ST_NONE;
    sel  = first_pend(r.pend);
    word = '0;
    n    = r;

    // millisecond timer, free running and wrapping
    if (ms_t.tick) begin
      n.ms = r.ms + TS_W'(1);   // see RL8
    end

    // event hand-out: the host read takes the held entry, then the next is loaded
    if (r.evt_valid && evt_ack_i) begin
      n.evt_valid = 1'b0;   // see RL13
    end
    if (!n.evt_valid && sel[CH_W]) begin
      n.evt_valid = 1'b1;
      n.evt_ch    = sel[CH_W-1:0];
      n.evt_state = r.ev_code[sel[CH_W-1:0]];
      n.evt_fault = is_fault(r.ev_code[sel[CH_W-1:0]]);
      n.evt_time  = r.ev_ts[sel[CH_W-1:0]];   // see RL13
      n.pend[sel[CH_W-1:0]] = 1'b0;
    end

    // per-channel logic; nothing here reads another slice, so a failed neighbour cannot reach it
    for (int i = 0; i < NCH; i++) begin   // see RL1, RL12
      g = i / GRP_SIZE;   // see RL9
      n.cmd_prev[i] = cmd_on_i[i];
      // short: overcurrent while on, or low load resistance while off when enabled
      sset = sup_ok_i[g] && (cmd_on_i[i] ? overcur_i[i]
                                          : (off_short_en_i[i] && low_res_i[i]));   // see RL5
      clr  = fault_reset_i || (cmd_on_i[i] != r.cmd_prev[i]);
      n.short_lat[i] = sset || (r.short_lat[i] && !clr);   // see RL15
      c = classify(sup_ok_i[g], n.short_lat[i], cmd_on_i[i], load_cur_i[i]);   // see RL2, RL16
      n.code[i]  = c;   // see RL3
      n.fault[i] = is_fault(c);   // see RL4
      // stuck tests are sticky until fault reset; a new hit wins over the reset
      n.stuck_on[i]  = (sup_ok_i[g] && !cmd_on_i[i] && volt_on_i[i])
                     || (r.stuck_on[i] && !fault_reset_i);   // see RL6
      n.stuck_off[i] = (sup_ok_i[g] && cmd_on_i[i] && !volt_on_i[i] && !n.short_lat[i])
                     || (r.stuck_off[i] && !fault_reset_i);   // see RL6
      // change capture; a second change before the entry is handed out overwrites the first
      if (log_en_i[i] && (r.code[i] != ST_NONE) && (c != r.code[i])) begin   // see RL7, RL14
        n.pend[i]    = 1'b1;
        n.ev_code[i] = c;
        n.ev_ts[i]   = r.ms;   // see RL13
      end
    end

    // field supply watch on the two extra measurement inputs
    n.fsup_alarm = fsup_mon_en_i ? ~fsup_ok_i : '0;   // see RL11

    // link: each channel sends {fault, code} msb first, sync marks channel 0 bit 0
    if (bit_t.tick) begin
      word      = {r.fault[r.lk_ch], r.code[r.lk_ch]};
      n.lk_dat  = word[LAST_BIT - r.lk_bit];   // see RL10
      n.lk_sync = (r.lk_ch == '0) && (r.lk_bit == '0);
      if (r.lk_bit == LAST_BIT) begin
        n.lk_bit = '0;
        n.lk_ch  = (r.lk_ch == LAST_CH) ? '0 : r.lk_ch + CH_W'(1);
      end else begin
        n.lk_bit = r.lk_bit + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign state_code_o = r.code;
  assign line_fault_o = r.fault;
  assign stuck_on_o   = r.stuck_on;
  assign stuck_off_o  = r.stuck_off;
  assign fsup_alarm_o = r.fsup_alarm;
  assign evt_valid_o  = r.evt_valid;
  assign evt_ch_o     = r.evt_ch;
  assign evt_state_o  = r.evt_state;
  assign evt_fault_o  = r.evt_fault;
  assign evt_time_o   = r.evt_time;
  assign link_dat_o   = r.lk_dat;
  assign link_sync_o  = r.lk_sync;
endmodule

// ==== verilog/rate_div.sv ====
// rate divider producing a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module rate_div #(
  parameter int unsigned DIV = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // enable pulse
  tick_if.src       t
);
  localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t r;
  div_state_t n;

  // count up a period, pulse on wrap
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == LAST) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign t.tick = r.tick;
endmodule

// ==== verilog/tick_if.sv ====
// one-cycle enable pulse carried from a rate divider to its user
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport src  (output tick);
  modport sink (input tick);
endinterface
